/* File: cfc_cfg.svh */
// Constants of the frame channel: timing, coding and register offsets.
// Included by the channel and by the testbench; definitions only.
`ifndef CFC_CFG_SVH
`define CFC_CFG_SVH
// One bus bit is 400 channel clock cycles
`define CFC_BIT_CYC     13'h0190
`define CFC_BIT_LAST    9'h18F
`define CFC_TOFFSET_RST 9'h0C8
// PWM low time of a 0 bit and of a 1 bit
`define CFC_PWM_LO0     9'h12C
`define CFC_PWM_LO1     9'h064
// Bit slots in a byte: start, 8 data LSB first, stop
`define CFC_BIT_D0      4'h1
`define CFC_BIT_D7      4'h8
`define CFC_BIT_STOP    4'h9
`define CFC_EOF_BITS    4'hA
`define CFC_EXT_CODE    4'hF
`define CFC_CRC_POLY    8'h1D
`define CFC_CRC_INIT    8'hFF
// Register byte addresses
`define CFC_A_CTL       8'h00
`define CFC_A_GAP       8'h04
`define CFC_A_CMD       8'h08
`define CFC_A_STS       8'h0C
`define CFC_A_ID        8'h10
`define CFC_A_FRM       8'h14
`define CFC_A_RXH       8'h18
`define CFC_A_TXD_HI    4'h2
`define CFC_A_RXD_HI    4'h3
`define CFC_A_ALIGN     2'h0
`endif

/* File: cfc_pkg.sv */
// Types of the frame channel: register layouts, states, bus carriers.
// Constants come from cfc_cfg.svh.
package cfc_pkg;
	typedef struct packed {
		logic [6:0] rsv1;
		logic [8:0] sample_offset;
		logic [10:0] rsv0;
		logic       zero_id_check;
		logic       polling;
		logic       encoding_select;
		logic       master;
		logic       enable;
	} cfc_ctl_t;
	typedef struct packed {
		logic [19:0] rsv;
		logic [3:0]  arbitration_retry_limit;
		logic [3:0]  frame_gap;
		logic [3:0]  byte_gap;
	} cfc_gap_t;
	typedef struct packed {
		logic [26:0] rsv;
		logic        rx_response;
		logic        rx_header;
		logic        idle_check_cmd;
		logic        tx_response;
		logic        tx_header;
	} cfc_cmd_t;
	typedef struct packed {
		logic [24:0] rsv;
		logic        busy;
		logic        parity_err;
		logic        crc_err;
		logic        retry_exhausted;
		logic        arb_lost;
		logic        transfer_complete_flag;
		logic        header_received_flag;
	} cfc_sts_t;
	typedef struct packed {
		logic [15:0] rsv;
		logic [7:0]  poll_grant_byte;
		logic        rsv1;
		logic [6:0]  frame_id;
	} cfc_id_t;
	typedef struct packed {
		logic [1:0] rolling_counter;
		logic [1:0] network_management_bits;
		logic [3:0] payload_length_code;
	} cfc_fcb_t;
	typedef struct packed {
		logic [15:0] rsv;
		logic [7:0]  extended_length_value;
		cfc_fcb_t    frame_control_byte;
	} cfc_frm_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} cfc_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} cfc_apb_rsp_t;
	typedef enum logic [2:0] {ST_IDLE, ST_IFS, ST_BYTE, ST_GAP, ST_WAIT, ST_EOF} cfc_st_t;
	typedef enum logic [2:0] {PH_POLL_GRANT_BYTE, PH_PID, PH_FCB, PH_EXT, PH_DATA, PH_CRC} cfc_ph_t;
	typedef struct packed {
		cfc_ctl_t         ctl;
		cfc_gap_t         gap;
		cfc_cmd_t         cmd;
		cfc_sts_t         sts;
		cfc_id_t          idr;
		cfc_frm_t         frm;
		logic [7:0]       rx_pid;
		logic [7:0]       rx_fcb;
		logic [7:0]       rx_ext;
		logic [7:0]       rx_crc;
		logic [15:0][7:0] txbuf;
		logic [15:0][7:0] rxbuf;
		cfc_st_t          st;
		cfc_ph_t          ph;
		logic             txing;
		logic [8:0]       bitcyc;
		logic [3:0]       bitn;
		logic [7:0]       txbyte;
		logic [7:0]       shreg;
		logic             rxbit;
		logic [7:0]       crc;
		logic [7:0]       idx;
		logic [7:0]       len;
		logic [12:0]      gapcnt;
		logic [3:0]       retries;
		logic             s1;
		logic             s2;
		logic             s3;
		logic             rxl;
		logic             rx_prev;
		logic             tx_o;
		logic             oe_n;
		cfc_apb_rsp_t     rsp;
	} cfc_state_t;
endpackage

/* File: cfc_frame_channel.sv */
// Single-wire clock-modulated bus channel, master or slave, with APB registers.
// Assumes clk_in is the dedicated channel clock and bus_rx_in reads back the line.
//
// Overview of operation
// - Polling master sends grant byte before identifier
// - Identifier is 7 bits plus odd parity
// - Control byte: counter, management, length code
// - Length code counts data bytes, not CRC
// - Response ends with an 8-bit CRC
// - Configurable byte gap between frame bytes
// - Long frames add extended length, data only
// - Five commands run autonomously from register
// - Idle check waits frame gap before sending
// - Event mode starts frames once bus idle; code waits only when idle_check_cmd is set
// - Polling transfers are initiated by the master
// - Dominant zero, smaller identifier wins arbitration; code sends LSB first, so a zero at the lowest differing bit wins
// - Readback mismatch in header bits flags loss
// - Loss compares retries with limit before retrying
// - Header received flag after identifier transfer
// - Response order: control, extension, data, CRC
// - End of frame after 10 bits sets complete
// - Slave polling zero-identifier check is optional
// - Bit is 400 cycles, sample offset configurable
// - Encoding select: 0 NRZ, 1 PWM
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "cfc_cfg.svh"
module cfc_frame_channel (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  rstn_in,
	// Register bus
	input  wire cfc_pkg::cfc_apb_req_t apb_req_in,
	output      cfc_pkg::cfc_apb_rsp_t apb_rsp_out,
	// Bus line
	input  wire logic                  bus_rx_in,
	output      logic                  bus_tx_out,
	output      logic                  bus_oe_n_out
);
	import cfc_pkg::*;

	localparam cfc_state_t RST = '{
		ctl: '{sample_offset: `CFC_TOFFSET_RST, default: '0},
		st: ST_IDLE, ph: PH_POLL_GRANT_BYTE,
		s1: 1'b1, s2: 1'b1, s3: 1'b1, rxl: 1'b1, rx_prev: 1'b1,
		tx_o: 1'b1, oe_n: 1'b1, default: '0};

	cfc_state_t s_q;
	cfc_state_t s_d;
	logic       fall;
	logic       acc;
	logic       prep;
	logic       hit_txd;
	logic       hit_rxd;
	logic       bitval;
	logic       lost;
	logic       hdr_bit;
	logic [7:0] b;
	cfc_fcb_t   fb;
	cfc_ph_t    hph;

	function automatic logic par(input logic [6:0] id);
		par = ~^id;
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `CFC_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	function automatic logic [12:0] bits2cyc(input logic [3:0] nb);
		bits2cyc = 13'(nb * `CFC_BIT_CYC);
	endfunction

	function automatic logic [31:0] word(input logic [15:0][7:0] bf, input logic [1:0] w);
		word = {bf[{w, 2'h3}], bf[{w, 2'h2}], bf[{w, 2'h1}], bf[{w, 2'h0}]};
	endfunction

	function automatic logic [7:0] tx_byte(input cfc_state_t t, input cfc_ph_t p);
		case (p)
			PH_POLL_GRANT_BYTE: tx_byte = t.idr.poll_grant_byte;
			PH_PID:   tx_byte = {par(t.idr.frame_id), t.idr.frame_id};
			PH_FCB:   tx_byte = t.frm.frame_control_byte;
			PH_EXT:   tx_byte = t.frm.extended_length_value;
			PH_DATA:  tx_byte = t.txbuf[t.idx[3:0]];
			default:  tx_byte = t.crc;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		fall = 1'b0;
		lost = 1'b0;
		b = s_q.shreg;
		fb = s_q.shreg;
		hph = (s_q.ctl.master && s_q.ctl.polling) ? PH_POLL_GRANT_BYTE : PH_PID;
		acc = apb_req_in.psel && apb_req_in.penable && s_q.rsp.pready;
		prep = apb_req_in.psel && apb_req_in.penable && !s_q.rsp.pready;
		hit_txd = apb_req_in.paddr[7:4] == `CFC_A_TXD_HI
			&& apb_req_in.paddr[1:0] == `CFC_A_ALIGN;
		hit_rxd = apb_req_in.paddr[7:4] == `CFC_A_RXD_HI
			&& apb_req_in.paddr[1:0] == `CFC_A_ALIGN;
		hdr_bit = s_q.txing && (s_q.ph == PH_POLL_GRANT_BYTE || s_q.ph == PH_PID)
			&& s_q.bitn >= `CFC_BIT_D0 && s_q.bitn <= `CFC_BIT_D7;
		bitval = 1'b1;
		if (s_q.bitn == 4'h0) begin
			bitval = 1'b0;
		end else if (s_q.bitn <= `CFC_BIT_D7) begin
			bitval = s_q.txbyte[0];
		end

		// Line synchroniser: a change counts once the last two stages agree
		s_d.s1 = bus_rx_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2 == s_q.s3) begin
			s_d.rxl = s_q.s3;
		end
		s_d.rx_prev = s_q.rxl;
		fall = s_q.rx_prev && !s_q.rxl;

		// APB: one wait state, write takes effect at the completing edge
		s_d.rsp.pready = prep;
		s_d.rsp.pslverr = 1'b0;
		if (prep) begin
			s_d.rsp.prdata = '0;
			case (apb_req_in.paddr)
				`CFC_A_CTL: s_d.rsp.prdata = s_q.ctl;
				`CFC_A_GAP: s_d.rsp.prdata = s_q.gap;
				`CFC_A_CMD: s_d.rsp.prdata = s_q.cmd;
				`CFC_A_STS: s_d.rsp.prdata = s_q.sts;
				`CFC_A_ID:  s_d.rsp.prdata = s_q.idr;
				`CFC_A_FRM: s_d.rsp.prdata = s_q.frm;
				`CFC_A_RXH: s_d.rsp.prdata = {s_q.rx_crc, s_q.rx_ext, s_q.rx_fcb, s_q.rx_pid};
				default: begin
					if (hit_txd) begin
						s_d.rsp.prdata = word(s_q.txbuf, apb_req_in.paddr[3:2]);
					end else if (hit_rxd) begin
						s_d.rsp.prdata = word(s_q.rxbuf, apb_req_in.paddr[3:2]);
					end else begin
						s_d.rsp.pslverr = 1'b1;
					end
				end
			endcase
		end
		if (acc && apb_req_in.pwrite) begin
			case (apb_req_in.paddr)
				`CFC_A_CTL: s_d.ctl = apb_req_in.pwdata;
				`CFC_A_GAP: s_d.gap = apb_req_in.pwdata;
				`CFC_A_CMD: s_d.cmd = apb_req_in.pwdata;
				`CFC_A_STS: s_d.sts = s_q.sts & ~apb_req_in.pwdata;
				`CFC_A_ID:  s_d.idr = apb_req_in.pwdata;
				`CFC_A_FRM: s_d.frm = apb_req_in.pwdata;
				default: begin
					if (hit_txd) begin
						for (int k = 0; k < 4; k++) begin
							s_d.txbuf[{apb_req_in.paddr[3:2], 2'(k)}] = apb_req_in.pwdata[8*k +: 8];
						end
					end
				end
			endcase
		end

		// Frame engine; hardware sets are applied after writes so a set wins
		case (s_q.st)
			ST_IDLE: begin
				s_d.txing = 1'b0;
				if (s_q.cmd.tx_header) begin
					if (s_q.ctl.polling && !s_q.ctl.master) begin
						s_d.ph = PH_POLL_GRANT_BYTE;
						s_d.st = ST_WAIT;
					end else begin
						s_d.gapcnt = '0;
						s_d.st = ST_IFS;
					end
				end else if (s_q.cmd.rx_header && fall) begin
					s_d.ph = PH_PID;
					s_d.bitcyc = '0;
					s_d.bitn = '0;
					s_d.st = ST_BYTE;
				end
			end
			ST_IFS: begin
				s_d.gapcnt = s_q.rxl ? s_q.gapcnt + 13'h0001 : '0;
				if (!s_q.cmd.idle_check_cmd || (s_q.rxl
						&& s_q.gapcnt >= bits2cyc(s_q.gap.frame_gap))) begin
					s_d.txing = 1'b1;
					s_d.ph = hph;
					s_d.txbyte = tx_byte(s_q, hph);
					s_d.bitcyc = '0;
					s_d.bitn = '0;
					s_d.st = ST_BYTE;
				end
			end
			ST_WAIT: begin
				if (s_q.ph == PH_FCB) begin
					s_d.crc = `CFC_CRC_INIT;
				end
				s_d.bitcyc = '0;
				s_d.bitn = '0;
				if (s_q.ph == PH_FCB && s_q.cmd.tx_response) begin
					s_d.txing = 1'b1;
					s_d.txbyte = tx_byte(s_q, PH_FCB);
					s_d.st = ST_BYTE;
				end else if (fall && (s_q.ph != PH_FCB || s_q.cmd.rx_response)) begin
					s_d.txing = 1'b0;
					s_d.st = ST_BYTE;
				end
			end
			ST_BYTE: begin
				s_d.bitcyc = s_q.bitcyc + 9'h001;
				if (s_q.bitcyc == s_q.ctl.sample_offset) begin
					s_d.rxbit = s_q.rxl;
					lost = hdr_bit && (s_q.rxl != s_q.txbyte[0]);
				end
				if (lost) begin
					s_d.sts.arb_lost = 1'b1;
					s_d.txing = 1'b0;
					s_d.gapcnt = '0;
					if (s_q.retries < s_q.gap.arbitration_retry_limit) begin
						s_d.retries = s_q.retries + 4'h1;
						s_d.st = ST_IFS;
					end else begin
						s_d.sts.retry_exhausted = 1'b1;
						s_d.cmd.tx_header = 1'b0;
						s_d.retries = '0;
						s_d.st = ST_IDLE;
					end
				end else if (s_q.bitcyc == `CFC_BIT_LAST) begin
					s_d.bitcyc = '0;
					s_d.bitn = s_q.bitn + 4'h1;
					if (s_q.bitn >= `CFC_BIT_D0 && s_q.bitn <= `CFC_BIT_D7) begin
						s_d.shreg = {s_q.rxbit, s_q.shreg[7:1]};
						s_d.txbyte = s_q.txbyte >> 1;
					end
					if (s_q.bitn == `CFC_BIT_STOP) begin
						s_d.gapcnt = '0;
						s_d.st = s_q.txing ? ST_GAP : ST_WAIT;
						case (s_q.ph)
							PH_POLL_GRANT_BYTE: begin
								s_d.ph = PH_PID;
								s_d.txing = 1'b1;
								s_d.st = ST_GAP;
							end
							PH_PID: begin
								s_d.rx_pid = b;
								s_d.ph = PH_FCB;
								if (!s_q.txing && b[7] != par(b[6:0])) begin
									s_d.sts.parity_err = 1'b1;
									s_d.st = ST_IDLE;
								end else if (!s_q.txing && s_q.ctl.zero_id_check
										&& s_q.ctl.polling && !s_q.ctl.master
										&& b[6:0] == 7'h00) begin
									s_d.st = ST_IDLE;
								end else begin
									s_d.sts.header_received_flag = 1'b1;
									s_d.cmd.tx_header = 1'b0;
									s_d.cmd.rx_header = 1'b0;
									s_d.retries = '0;
								end
							end
							PH_FCB: begin
								s_d.rx_fcb = b;
								s_d.crc = crc8(s_q.crc, b);
								s_d.len = {4'h0, fb.payload_length_code};
								s_d.idx = '0;
								if (fb.payload_length_code == `CFC_EXT_CODE) begin
									s_d.ph = PH_EXT;
								end else if (fb.payload_length_code == 4'h0) begin
									s_d.ph = PH_CRC;
								end else begin
									s_d.ph = PH_DATA;
								end
							end
							PH_EXT: begin
								s_d.rx_ext = b;
								s_d.crc = crc8(s_q.crc, b);
								s_d.len = b;
								s_d.ph = (b == 8'h00) ? PH_CRC : PH_DATA;
							end
							PH_DATA: begin
								s_d.crc = crc8(s_q.crc, b);
								if (!s_q.txing) begin
									s_d.rxbuf[s_q.idx[3:0]] = b;
								end
								s_d.idx = s_q.idx + 8'h01;
								if (s_q.idx + 8'h01 == s_q.len) begin
									s_d.ph = PH_CRC;
								end
							end
							default: begin
								s_d.rx_crc = b;
								if (!s_q.txing && b != s_q.crc) begin
									s_d.sts.crc_err = 1'b1;
								end
								s_d.txing = 1'b0;
								s_d.st = ST_EOF;
							end
						endcase
					end
				end
			end
			ST_GAP: begin
				s_d.gapcnt = s_q.gapcnt + 13'h0001;
				s_d.bitcyc = '0;
				s_d.bitn = '0;
				if (s_q.gapcnt >= bits2cyc(s_q.gap.byte_gap)) begin
					if (s_q.ph == PH_FCB) begin
						s_d.txing = 1'b0;
						s_d.st = ST_WAIT;
					end else begin
						s_d.txbyte = tx_byte(s_q, s_q.ph);
						s_d.st = ST_BYTE;
					end
				end
			end
			ST_EOF: begin
				s_d.gapcnt = s_q.gapcnt + 13'h0001;
				if (s_q.gapcnt == bits2cyc(`CFC_EOF_BITS) - 13'h0001) begin
					s_d.sts.transfer_complete_flag = 1'b1;
					s_d.cmd.tx_response = 1'b0;
					s_d.cmd.rx_response = 1'b0;
					s_d.cmd.idle_check_cmd = 1'b0;
					s_d.st = ST_IDLE;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase

		// Line level; PWM carries the bit in the low time of each slot
		s_d.tx_o = 1'b1;
		if (s_q.st == ST_BYTE && s_q.txing) begin
			if (s_q.ctl.encoding_select) begin
				s_d.tx_o = s_q.bitcyc >= (bitval ? `CFC_PWM_LO1 : `CFC_PWM_LO0);
			end else begin
				s_d.tx_o = bitval;
			end
		end
		s_d.oe_n = !s_q.ctl.enable;

		// Disabling drops frame state but keeps configuration
		if (!s_q.ctl.enable) begin
			s_d.st = ST_IDLE;
			s_d.sts = '0;
			s_d.cmd = '0;
			s_d.txing = 1'b0;
			s_d.retries = '0;
			s_d.tx_o = 1'b1;
		end
		s_d.sts.busy = s_d.st != ST_IDLE;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_q <= RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp_out = s_q.rsp;
	assign bus_tx_out = s_q.tx_o;
	assign bus_oe_n_out = s_q.oe_n;
endmodule

/* File: cfc_checker.sv */
// Checker of the frame channel: register handshake and line waveform.
// Sees only the channel's ports; bound to the channel at the foot.
`timescale 1ns/1ps
module cfc_checker (
	// Clock and reset
	input wire logic                  clk_in,
	input wire logic                  rstn_in,
	// Register bus
	input wire cfc_pkg::cfc_apb_req_t apb_req_in,
	input wire cfc_pkg::cfc_apb_rsp_t apb_rsp_out,
	// Bus line
	input wire logic                  bus_rx_in,
	input wire logic                  bus_tx_out,
	input wire logic                  bus_oe_n_out
);
	import cfc_pkg::*;
	logic [12:0] fall_gap_q;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Saturates so a long idle never wraps into a short gap
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fall_gap_q <= 13'h1FFF;
		end else if ($fell(bus_tx_out)) begin
			fall_gap_q <= 13'h0000;
		end else if (fall_gap_q != 13'h1FFF) begin
			fall_gap_q <= fall_gap_q + 13'h0001;
		end
	end
	pready_pulse_a: assert property (
		apb_rsp_out.pready |=> !apb_rsp_out.pready) else $error("pready too long");
	access_wait_a: assert property (
		apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready |=> apb_rsp_out.pready)
		else $error("no answer after access");
	ready_access_a: assert property (
		apb_rsp_out.pready |-> apb_req_in.psel && apb_req_in.penable) else $error("stray pready");
	slverr_ready_a: assert property (
		apb_rsp_out.pslverr |-> apb_rsp_out.pready) else $error("stray pslverr");
	err_data_a: assert property (
		apb_rsp_out.pslverr |-> apb_rsp_out.prdata == 32'h0) else $error("refused read data");
	bit_time_a: assert property (
		$fell(bus_tx_out) |-> fall_gap_q >= 13'h018F) else $error("bit slot too short");
	idle_recessive_a: assert property (
		bus_oe_n_out |-> bus_tx_out) else $error("drive while disabled");
	low_pulse_a: assert property (
		$fell(bus_tx_out) |-> !bus_tx_out [*8]) else $error("low pulse too short");
endmodule
bind cfc_frame_channel cfc_checker i_chk (
	.clk_in      (clk_in),
	.rstn_in     (rstn_in),
	.apb_req_in  (apb_req_in),
	.apb_rsp_out (apb_rsp_out),
	.bus_rx_in   (bus_rx_in),
	.bus_tx_out  (bus_tx_out),
	.bus_oe_n_out(bus_oe_n_out)
);

/* File: cfc_bus_node.sv */
// Model of another node on the single wire: receives and sends bytes.
// Assumes the testbench forms the wired-AND line with a pull-up.
`timescale 1ns/1ps
module cfc_bus_node (
	// Clock
	input  wire logic clk_in,
	// Bus line
	input  wire logic line_in,
	output      logic drv_out
);
	logic [7:0] q[$];
	logic [9:0] sh;
	logic       busy = 1'b0;
	initial drv_out = 1'b1;
	// Mid-slot sampling reads NRZ levels and PWM widths alike
	always begin
		@(negedge line_in);
		if (!busy) begin
			repeat (200) @(posedge clk_in);
			for (int i = 0; i < 10; i++) begin
				sh[i] = line_in;
				if (i < 9) repeat (400) @(posedge clk_in);
			end
			if (!sh[0] && sh[9]) q.push_back(sh[8:1]);
		end
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		busy = 1'b1;
		for (int i = 0; i < 10; i++) begin
			drv_out <= f[i];
			repeat (400) @(posedge clk_in);
		end
		busy = 1'b0;
		repeat (400) @(posedge clk_in);
	endtask
	// Dominant low over start and first identifier bit wins the line
	task automatic jam();
		@(negedge line_in);
		@(posedge clk_in);
		drv_out <= 1'b0;
		repeat (800) @(posedge clk_in);
		drv_out <= 1'b1;
	endtask
endmodule

/* File: cfc_testbench.sv */
// Testbench of the frame channel: registers, frames both ways, arbitration.
// Assumes the bus node model on the line and the bound checker.
`timescale 1ns/1ps
`include "cfc_cfg.svh"
module testbench;
	import cfc_pkg::*;
	logic         clk_in = 1'b0;
	logic         rstn_in = 1'b0;
	cfc_apb_req_t req = '0;
	cfc_apb_rsp_t rsp;
	logic         tx;
	logic         oe_n;
	logic         drv;
	logic         line;
	int           failures = 0;
	int           n_tests = 0;
	int           cyc = 0;
	assign line = (oe_n | tx) & drv;
	always #4 clk_in = ~clk_in;
	always @(posedge clk_in) cyc <= cyc + 1;
	cfc_frame_channel i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .apb_req_in(req),
		.apb_rsp_out(rsp), .bus_rx_in(line), .bus_tx_out(tx), .bus_oe_n_out(oe_n));
	cfc_bus_node i_node (.clk_in(clk_in), .line_in(line), .drv_out(drv));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t %s got %h", $time, what, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_in);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_in);
		req.penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do @(posedge clk_in); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic wait_sts(input int b, output logic [31:0] r);
		logic e;
		r = '0;
		for (int n = 0; n < 9000 && r[b] !== 1'b1; n++) apb(1'b0, `CFC_A_STS, 32'h0, r, e);
	endtask
	task automatic cfg(input logic [31:0] ctl, input logic [31:0] gap);
		wr(`CFC_A_CTL, ctl & 32'hFFFF_FFFE);
		wr(`CFC_A_GAP, gap);
		wr(`CFC_A_CTL, ctl);
		i_node.q.delete();
	endtask
	task automatic chk_q(input logic [7:0] e[$], input string what);
		chk(i_node.q.size(), e.size(), what);
		foreach (e[i]) chk({24'h0, i_node.q[i]}, {24'h0, e[i]}, what);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] b[$]);
		logic [7:0] c;
		c = `CFC_CRC_INIT;
		foreach (b[i]) begin
			c = c ^ b[i];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ `CFC_CRC_POLY : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		apb(1'b0, `CFC_A_CTL, 32'h0, r, e);
		chk(r, 32'h00C8_0000, "control reset");
		apb(1'b0, 8'hFC, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1, "unmapped read");
	endtask
	task automatic t_header(input logic [31:0] ctl);
		logic [31:0] r;
		logic [7:0] protected_identifier;
		protected_identifier = {~^7'h35, 7'h35};
		cfg(ctl, 32'h0000_0011);
		wr(`CFC_A_ID, 32'h0000_A535);
		wr(`CFC_A_CMD, 32'h0000_0015);
		wait_sts(0, r);
		chk(r & 32'h1, 32'h1, "header flag");
		if (ctl[3]) begin
			chk_q('{8'hA5, protected_identifier}, "grant and identifier");
		end else begin
			chk_q('{protected_identifier}, "identifier");
		end
	endtask
	task automatic t_resp();
		logic [31:0] r;
		logic [7:0] d[$];
		int t0;
		d = '{8'h63, 8'h11, 8'h22, 8'h33};
		i_node.q.delete();
		wr(`CFC_A_FRM, 32'h0000_0063);
		wr({`CFC_A_TXD_HI, 4'h0}, 32'h4433_2211);
		wr(`CFC_A_CMD, 32'h0000_0002);
		while (i_node.q.size() < 5) @(posedge clk_in);
		t0 = cyc;
		wait_sts(1, r);
		chk(32'(cyc - t0 >= 4100 && cyc - t0 <= 4300), 32'h1, "end of frame");
		d.push_back(crc8(d));
		chk_q(d, "response bytes");
	endtask
	task automatic t_rx();
		logic [31:0] r;
		logic e;
		logic [7:0] f[$];
		f = '{8'h0F, 8'h02, 8'hAA, 8'h55};
		cfg(32'h00C8_0001, 32'h0000_0011);
		wr(`CFC_A_CMD, 32'h0000_0018);
		i_node.send({~^7'h0A, 7'h0A});
		foreach (f[i]) i_node.send(f[i]);
		i_node.send(crc8(f));
		wait_sts(1, r);
		chk(r & 32'h32, 32'h2, "received frame");
		apb(1'b0, {`CFC_A_RXD_HI, 4'h0}, 32'h0, r, e);
		chk(r & 32'hFFFF, 32'h55AA, "received data");
		apb(1'b0, `CFC_A_RXH, 32'h0, r, e);
		chk(r & 32'h00FF_FFFF, 32'h0002_0F8A, "received header");
	endtask
	// Polling slave: zero identifier ignored, then grant byte answered
	task automatic t_slave();
		logic [31:0] r;
		logic e;
		logic [7:0] protected_identifier;
		protected_identifier = {~^7'h35, 7'h35};
		cfg(32'h00C8_0019, 32'h0000_0011);
		wr(`CFC_A_CMD, 32'h0000_0018);
		i_node.send({~^7'h00, 7'h00});
		apb(1'b0, `CFC_A_STS, 32'h0, r, e);
		chk(r & 32'h21, 32'h0, "zero identifier");
		wr(`CFC_A_ID, 32'h0000_0035);
		wr(`CFC_A_CMD, 32'h0000_0019);
		i_node.send(8'hA5);
		wait_sts(0, r);
		chk(r & 32'h1, 32'h1, "slave header flag");
		chk_q('{protected_identifier}, "slave identifier");
	endtask
	task automatic t_arb(input logic [3:0] lim);
		logic [31:0] r;
		cfg(32'h00C8_0003, {20'h0, lim, 8'h11});
		wr(`CFC_A_ID, 32'h0000_007F);
		fork
			i_node.jam();
		join_none
		wr(`CFC_A_CMD, 32'h0000_0015);
		wait_sts(lim != 0 ? 0 : 3, r);
		chk(r & 32'h0D, lim != 0 ? 32'h05 : 32'h0C, "arbitration");
	endtask
	task automatic results();
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_regs();
		t_header(32'h00C8_0007);
		t_header(32'h00C8_0003);
		t_resp();
		t_header(32'h00C8_000B);
		t_rx();
		t_slave();
		t_arb(4'h0);
		t_arb(4'h1);
		results();
	end
	// About 92000 cycles of traffic fit inside this span of 98750 cycles
	initial begin
		#790000;
		failures++;
		results();
	end
endmodule
